// ### core/ecm_mailbox.sv
// Purpose: Feedback housekeeping flags and encoder comms mailbox.
// Assumes: Link byte ports and trip inputs are on clock_in.
// Notes:   Only the nameplate strap arrives from a pin.
`timescale 1ns/1ns
module ecm_mailbox
    import ecm_pkg::*;
#(
    parameter int LOCK_CYC_P = LOCK_CYC,
    parameter int TMO_CYC_P  = TMO_CYC
) (
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        main_init_done_in,
    input  wire logic        module_init_done_in,
    input  wire logic        trip_valid_in,
    input  wire logic [4:0]  trip_code_in,
    input  wire logic        trip_reinit_in,
    input  wire logic        trip_reset_in,
    output logic             reinit_req_out,
    output logic             feedback_initialised_flag_out,
    input  wire logic        power_en_req_in,
    output logic             power_stage_en_out,
    input  wire logic        full_nameplate_transfer_en_in,
    input  wire logic        motor_object_valid_in,
    input  ecm_word_t [6:0]  motor_object_in,
    input  ecm_pos_t         pos_in,
    output ecm_pos_t         pos_out,
    output ecm_byte_t        link_tx_out,
    output logic             link_tx_valid_out,
    input  wire logic        link_tx_ready_in,
    input  ecm_byte_t        link_rx_in,
    input  wire logic        link_rx_valid_in,
    input  wire logic        link_rx_err_in
);
    ecm_state_t  st_r;
    logic [2:0]  ctrl_r;
    logic [15:0] tx_r;
    logic [15:0] rx_r;
    logic [7:0]  sts_r;
    logic [7:0]  buf_r [16];
    logic [7:0]  rbuf_r [16];
    logic [4:0]  wptr_r;
    logic [4:0]  sidx_r;
    logic [4:0]  ridx_r;
    logic [4:0]  rdx_r;
    logic [7:0]  csum_r;
    logic [7:0]  rsum_r;
    logic        ovf_r;
    logic        rerr_r;
    logic        chk_r;
    logic [21:0] tmo_r;
    logic        flag_r;
    logic        pend_r;
    logic        low_r;
    logic        trip_r;
    logic        np_s1_r;
    logic        np_s2_r;
    logic [1:0]  cap_r;
    logic        np_act_r;
    ecm_word_t   np_r [NP_WORDS];
    logic [18:0] lk_cnt_r;
    logic        lock_r;

    // APB: no wait state; read data is registered from the setup cycle into a flop
    wire [7:0] rd_ofs  = {paddr_in[7:2], 2'b00};
    wire [2:0] np_idx  = 3'(rd_ofs[4:2] - 3'd4);
    wire is_np   = (rd_ofs >= OFS_NP0) && (rd_ofs < 8'h2c);
    wire mapped  = is_np || (rd_ofs <= OFS_STAT);
    wire setup   = psel_in && !penable_in;
    wire acc     = psel_in && penable_in && pready_out;
    wire wr_tx   = acc && pwrite_in && rd_ofs == OFS_TX && ctrl_r[CTRL_CHAN];
    wire wr_rx   = acc && pwrite_in && rd_ofs == OFS_RX;
    wire wr_ctrl = acc && pwrite_in && rd_ofs == OFS_CTRL;
    wire [31:0] rd_nxt =
        (rd_ofs == OFS_TX)   ? {16'h0, tx_r} :
        (rd_ofs == OFS_RX)   ? {16'h0, rx_r} :
        (rd_ofs == OFS_CTRL) ? {29'h0, ctrl_r} :
        (rd_ofs == OFS_STAT) ? {24'h0, sts_r[5:0], lock_r, flag_r} :
        is_np                ? {16'h0, np_r[np_idx]} : 32'h0;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
            ctrl_r      <= CTRL_RST;
        end else begin
            pready_out  <= setup;
            pslverr_out <= setup && !mapped;
            prdata_out  <= setup ? rd_nxt : 32'h0;
            if (wr_ctrl) ctrl_r <= pwdata_in[2:0];
        end
    end

    // Initialised flag and enable interlock
    wire trip_hit = trip_valid_in && trip_reinit_in &&
                    trip_code_in >= TRIP_FIRST && trip_code_in <= TRIP_LAST;
    wire all_done = main_init_done_in && module_init_done_in;
    wire trip_rst = trip_reset_in && trip_r;
    wire flag_nxt = trip_hit ? 1'b0 :
                    (pend_r && !trip_r && !low_r && all_done) ? 1'b1 : flag_r;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            flag_r <= 1'b0;
            pend_r <= 1'b1;
            low_r  <= 1'b0;
            trip_r <= 1'b0;
            reinit_req_out <= 1'b0;
            power_stage_en_out <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            pend_r <= (pend_r && !flag_nxt) || trip_rst;
            // Stale done levels must drop before the flag may rise again
            low_r  <= trip_rst || (low_r && all_done);
            trip_r <= trip_hit || (trip_r && !trip_reset_in);
            reinit_req_out <= trip_rst;
            power_stage_en_out <= power_en_req_in && flag_nxt;
        end
    end
    assign feedback_initialised_flag_out = flag_r;

    // Nameplate strap: synchronised, caught once after reset release
    always_ff @(posedge clock_in) begin
        np_s1_r <= full_nameplate_transfer_en_in;
        np_s2_r <= np_s1_r;
        if (srst_in) begin
            cap_r    <= 2'd0;
            np_act_r <= 1'b0;
        end else if (cap_r != 2'd3) begin
            cap_r <= 2'(cap_r + 2'd1);
            if (cap_r == 2'd2) np_act_r <= np_s2_r;
        end
    end

    for (genvar g = 0; g < NP_WORDS; g++) begin : g_np
        always_ff @(posedge clock_in) begin
            if (srst_in) np_r[g] <= 16'h0;
            else if (np_act_r && motor_object_valid_in)
                np_r[g] <= motor_object_in[g];
        end
    end

    // Feedback lock sampled on a 4 ms tick
    wire lk_tick = lk_cnt_r == 19'(LOCK_CYC_P - 1);
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            lk_cnt_r <= 19'h0;
            lock_r   <= 1'b0;
            pos_out  <= '0;
        end else begin
            lk_cnt_r <= lk_tick ? 19'h0 : 19'(lk_cnt_r + 19'h1);
            if (lk_tick) lock_r <= ctrl_r[CTRL_LOCK];
            if (!lock_r) pos_out <= pos_in;
        end
    end

    // Transmit side of the mailbox
    wire       async   = !ctrl_r[CTRL_SYNC];
    wire       take    = tx_r[MB_VALID] && st_r == ST_IDLE && !chk_r;
    wire       first   = tx_r[MB_FIRST];
    wire [4:0] ptr     = first ? 5'd0 : wptr_r;
    wire       full    = ptr == BUF_DEPTH;
    wire [7:0] cmd     = async ? buf_r[1] : buf_r[0];
    wire [4:0] exp_len = ecm_hf_len(cmd);
    wire e_len = async && exp_len != 5'd0 && exp_len != wptr_r;
    wire e_ovf = async && (ovf_r || wptr_r > ASYNC_MAX);
    wire e_cmd = async ? !ecm_hf_ok(cmd) : !ecm_sy_ok(cmd);
    wire [5:0] chk_err = {3'b0, e_cmd, e_ovf, e_len};
    wire [4:0] s_last  = async ? wptr_r : 5'(wptr_r - 5'd1);
    wire       tx_go   = !link_tx_valid_out || link_tx_ready_in;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tx_r   <= 16'h0;
            wptr_r <= 5'd0;
            ovf_r  <= 1'b0;
            csum_r <= 8'h0;
            chk_r  <= 1'b0;
        end else begin
            chk_r <= take && tx_r[MB_LAST];
            if (wr_tx) tx_r <= {pwdata_in[15:13], 5'h0, pwdata_in[7:0]};
            else if (take) tx_r <= 16'h0;
            if (take) begin
                if (!full) buf_r[ptr[3:0]] <= tx_r[7:0];
                wptr_r <= full ? ptr : 5'(ptr + 5'd1);
                ovf_r  <= full || (ovf_r && !first);
                csum_r <= (first ? 8'h0 : csum_r) ^ tx_r[7:0];
            end
        end
    end

    // Receive side and state machine
    wire       rx_hit  = st_r == ST_WAIT && link_rx_valid_in;
    wire       rx_end  = rx_hit && link_rx_in.last;
    wire [7:0] rsum    = rsum_r ^ link_rx_in.data;
    wire       r_ovf   = ridx_r == BUF_DEPTH;
    wire [5:0] rx_err  = {1'b0, async && rsum != 8'h0,
                          rerr_r || link_rx_err_in, 1'b0, r_ovf, 1'b0};
    wire       tmo_hit = st_r == ST_WAIT && tmo_r == 22'(TMO_CYC_P - 1);
    wire       rx_held = rx_r[MB_VALID];
    wire       rx_load = st_r == ST_DELIV && !rx_held;
    wire       rx_done = st_r == ST_DELIV && rx_held && wr_rx && rx_r[MB_LAST];

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st_r   <= ST_IDLE;
            sts_r  <= 8'h0;
            sidx_r <= 5'd0;
            ridx_r <= 5'd0;
            rdx_r  <= 5'd0;
            rsum_r <= 8'h0;
            rerr_r <= 1'b0;
            tmo_r  <= 22'h0;
            link_tx_valid_out <= 1'b0;
            link_tx_out <= '0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    sidx_r <= 5'd0;
                    ridx_r <= 5'd0;
                    rsum_r <= 8'h0;
                    rerr_r <= 1'b0;
                    tmo_r  <= 22'h0;
                    if (take) sts_r <= 8'h0;
                    if (chk_r && chk_err != 6'h0) sts_r <= {2'b0, chk_err};
                    else if (chk_r) st_r <= ST_SEND;
                end
                ST_SEND: begin
                    if (tx_go && sidx_r <= s_last) begin
                        link_tx_valid_out <= 1'b1;
                        link_tx_out.data <= (async && sidx_r == wptr_r) ?
                                            csum_r : buf_r[sidx_r[3:0]];
                        link_tx_out.last <= sidx_r == s_last;
                        sidx_r <= 5'(sidx_r + 5'd1);
                    end else if (tx_go) begin
                        link_tx_valid_out <= 1'b0;
                        st_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    tmo_r <= 22'(tmo_r + 22'h1);
                    if (rx_hit) begin
                        if (!r_ovf) rbuf_r[ridx_r[3:0]] <= link_rx_in.data;
                        ridx_r <= r_ovf ? ridx_r : 5'(ridx_r + 5'd1);
                        rsum_r <= rsum;
                        rerr_r <= rerr_r || link_rx_err_in || r_ovf;
                    end
                    if (rx_end) begin
                        sts_r <= {2'b0, rx_err};
                        rdx_r <= 5'd0;
                        st_r  <= rx_err != 6'h0 ? ST_IDLE : ST_DELIV;
                    end else if (tmo_hit) begin
                        sts_r[STS_TMO] <= 1'b1;
                        st_r <= ST_IDLE;
                    end
                end
                ST_DELIV: begin
                    if (rx_load) rdx_r <= 5'(rdx_r + 5'd1);
                    if (rx_done) st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Receive register: status word outside delivery, bytes during it
    wire [4:0]  rx_cnt = r_ovf ? ridx_r : ridx_r;
    wire        rx_lst = rdx_r == 5'(rx_cnt - 5'd1);
    wire [15:0] rx_byte = {1'b1, rx_lst, 6'h0, rbuf_r[rdx_r[3:0]]};
    always_ff @(posedge clock_in) begin
        if (srst_in) rx_r <= 16'h0;
        else if (st_r != ST_DELIV) rx_r <= {3'b001, 5'h0, sts_r};
        else if (rx_load) rx_r <= rx_byte;
        else if (wr_rx) rx_r <= 16'h0;
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    sequence s_taken_last;
        take && tx_r[MB_LAST];
    endsequence
    sequence s_checked;
        chk_r ##1 (st_r == ST_SEND || sts_r != 8'h0);
    endsequence

    a_power_interlock: assert property (
        power_stage_en_out |-> feedback_initialised_flag_out)
        else $error("power stage enabled while not initialised");
    a_trip_clears: assert property (
        trip_hit |=> !flag_r ##1 !power_stage_en_out)
        else $error("encoder trip did not clear flag");
    a_reinit_pulse: assert property (
        trip_rst |=> reinit_req_out ##1 !reinit_req_out)
        else $error("re-init request not one cycle");
    a_flag_sets: assert property (
        pend_r && !trip_r && !low_r && all_done && !trip_hit |=> flag_r)
        else $error("flag not set after initialisation");
    a_lock_freeze: assert property (
        lock_r && $past(lock_r) |-> $stable(pos_out))
        else $error("position changed while locked");
    a_tx_clear: assert property (
        take && !wr_tx |=> tx_r == 16'h0)
        else $error("transmit register not cleared");
    a_first_ptr: assert property (
        take && first |=> wptr_r == 5'd1)
        else $error("first byte did not restart pointer");
    a_last_sends: assert property (
        s_taken_last |=> s_checked)
        else $error("last byte did not start send or report");
    a_rx_next: assert property (
        st_r == ST_DELIV && rx_held && wr_rx && !rx_r[MB_LAST]
        |=> rx_r == 16'h0 ##1 rx_r[MB_VALID])
        else $error("next byte not loaded after clear");
    a_unused_zero: assert property (
        rx_r[12:8] == 5'h0 && tx_r[12:8] == 5'h0)
        else $error("unused mailbox bits set");
    a_status_show: assert property (
        st_r == ST_IDLE && !chk_r |=> rx_r[MB_FIRST] && !rx_r[MB_VALID])
        else $error("status word not shown when idle");
endmodule

// ### core/ecm_pkg.sv
// Purpose: Constants and types for the encoder comms mailbox block.
// Assumes: 125 MHz clock, APB register access, 32-bit data.
// Notes:   Command tables cover both byte protocols; the length table is async only.
// Summary of operation
// - Init flag zero until all encoders initialised
// - Power stage enable blocked while flag zero
// - Encoder trip first..last clears flag, blocks enable
// - Trip reset re-initialises encoder, then sets flag
// - Nameplate copy enable sampled only at reset
// - Feedback lock freezes position outputs, sampled 4ms
// - Transmit bit 15 required to take byte
// - Transmit bit 14 stores last byte, starts send
// - Transmit bit 13 resets write pointer first
// - Receive bit 15 marks a readable response byte
// - Receive bit 14 marks final response byte
// - Receive bit 13 shows status; errors persist
// - Taken transmit word clears register to zero
// - Host clears receive register; next byte follows
// - Sixteen byte buffer; async message over 15 bytes is error
// - Status bit 0: length mismatch, async only
// - Status bit 1: buffer overflow, async only on transmit, any mode on receive
// - Status bits 2-5: command, encoder, checksum, timeout
// - Async checksum appended on send, checked on reply
package ecm_pkg;
    localparam logic [7:0] OFS_TX   = 8'h00;
    localparam logic [7:0] OFS_RX   = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_NP0  = 8'h10;
    localparam int NP_WORDS = 7;
    localparam int MB_VALID = 15;
    localparam int MB_LAST  = 14;
    localparam int MB_FIRST = 13;
    localparam int CTRL_CHAN = 0;
    localparam int CTRL_LOCK = 1;
    localparam int CTRL_SYNC = 2;
    localparam int STS_LEN = 0;
    localparam int STS_OVF = 1;
    localparam int STS_CMD = 2;
    localparam int STS_ENC = 3;
    localparam int STS_SUM = 4;
    localparam int STS_TMO = 5;
    localparam logic [4:0] BUF_DEPTH = 5'd16;
    localparam logic [4:0] ASYNC_MAX = 5'd15;
    localparam logic [4:0] SYNC_LEN  = 5'd4;
    localparam logic [4:0] TRIP_FIRST = 5'd1;
    localparam logic [4:0] TRIP_LAST  = 5'd17;
    localparam logic [2:0] CTRL_RST  = 3'h0;
    localparam int CLK_KHZ  = 125000;
    localparam int LOCK_MS  = 4;
    localparam int LOCK_CYC = CLK_KHZ * LOCK_MS;
    localparam int TMO_MS   = 20;
    localparam int TMO_CYC  = CLK_KHZ * TMO_MS;

    typedef logic [15:0] ecm_word_t;
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } ecm_byte_t;
    typedef struct packed {
        logic [15:0] rev;
        logic [15:0] coarse;
        logic [15:0] fine;
    } ecm_pos_t;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SEND  = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_DELIV = 4'b1000
    } ecm_state_t;

    // Async protocol commands; 0 means length is not checked
    function automatic logic [4:0] ecm_hf_len(input logic [7:0] c);
        case (c)
            8'h42:   ecm_hf_len = 5'd2;
            8'h4d:   ecm_hf_len = 5'd5;
            default: ecm_hf_len = 5'd0;
        endcase
    endfunction
    function automatic logic ecm_hf_ok(input logic [7:0] c);
        case (c)
            8'h42, 8'h43, 8'h44, 8'h46, 8'h47, 8'h49, 8'h4a,
            8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h50, 8'h52, 8'h53:
                ecm_hf_ok = 1'b1;
            default: ecm_hf_ok = 1'b0;
        endcase
    endfunction
    function automatic logic ecm_sy_ok(input logic [7:0] c);
        ecm_sy_ok = (c == 8'h00) || (c == 8'h01) || (c == 8'h03) ||
                    (c == 8'h04) || (c == 8'h05);
    endfunction
endpackage

// ### dv/ecm_enc_model.sv
// Purpose: Behavioural position encoder on the byte link.
// Assumes: One fixed position reply, checksum as its last byte.
// Notes:   Knobs let the bench stall, mute, corrupt or flag the reply.
`timescale 1ns/1ns
module ecm_enc_model
    import ecm_pkg::*;
(
    input  wire logic clock_in,
    input  wire logic srst_in,
    input  ecm_byte_t link_tx_in,
    input  wire logic link_tx_valid_in,
    output logic      link_tx_ready_out,
    output ecm_byte_t link_rx_out,
    output logic      link_rx_valid_out,
    output logic      link_rx_err_out,
    input  wire logic slow_in,
    input  wire logic mute_in,
    input  wire logic bad_sum_in,
    input  wire logic enc_err_in
);
    localparam logic [7:0] RSP [7] = '{8'h40, 8'h42, 8'h03, 8'h59, 8'h63, 8'h97, 8'hac};
    logic [2:0] idx_r;
    logic       busy_r;
    logic       tog_r;
    wire        go = !slow_in || tog_r;
    assign link_tx_ready_out = go;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            idx_r             <= 3'h0;
            busy_r            <= 1'b0;
            tog_r             <= 1'b0;
            link_rx_out       <= '0;
            link_rx_valid_out <= 1'b0;
            link_rx_err_out   <= 1'b0;
        end else begin
            tog_r             <= ~tog_r;
            link_rx_valid_out <= 1'b0;
            link_rx_err_out   <= 1'b0;
            // Idle data keeps moving so a stale byte is never mistaken for a fresh one
            link_rx_out       <= ~link_rx_out;
            if (link_tx_valid_in && go && link_tx_in.last && !mute_in) begin
                busy_r <= 1'b1;
                idx_r  <= 3'h0;
            end
            if (busy_r && go) begin
                link_rx_valid_out <= 1'b1;
                link_rx_err_out   <= enc_err_in;
                link_rx_out       <= {RSP[idx_r] ^ {7'h0, bad_sum_in && idx_r == 3'h6},
                                      idx_r == 3'h6};
                idx_r             <= idx_r + 3'h1;
                busy_r            <= idx_r != 3'h6;
            end
        end
    end
endmodule

// ### dv/encoder_comms_mailbox_tb.sv
// Purpose: Self-checking bench for the encoder comms mailbox.
// Assumes: APB master tasks here; encoder model on the byte link.
// Notes:   Short lock and timeout counts keep the run brief.
`timescale 1ns/1ns
module encoder_comms_mailbox_tb;
    import ecm_pkg::*;
    typedef struct {
        logic [7:0]  a;
        logic        w;
        logic [31:0] wd;
        logic [31:0] d;
        logic        e;
    } ecm_row_t;
    localparam int LK = 16;
    logic        clock_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
    logic        pwrite_in = 1'b0, pready_out, pslverr_out, err_seen, reinit_req_out;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd, ex;
    logic        main_init_done_in = 1'b0, module_init_done_in = 1'b0, trip_valid_in = 1'b0;
    logic        trip_reinit_in = 1'b0, trip_reset_in = 1'b0, power_en_req_in = 1'b1;
    logic        full_nameplate_transfer_en_in = 1'b1, motor_object_valid_in = 1'b0;
    logic        feedback_initialised_flag_out, power_stage_en_out, link_tx_valid_out;
    logic        link_tx_ready_in, link_rx_valid_in, link_rx_err_in;
    logic        slow = 1'b0, mute = 1'b0, bad = 1'b0, enc_err = 1'b0;
    logic [4:0]  trip_code_in = 5'h00;
    ecm_word_t [6:0] motor_object_in = '0;
    ecm_pos_t    pos_in = '0, pos_out;
    ecm_byte_t   link_tx_out, link_rx_in;
    ecm_byte_t   seen[$];
    logic [7:0]  rsp [7] = '{8'h40, 8'h42, 8'h03, 8'h59, 8'h63, 8'h97, 8'hac};
    int          fails = 0, checked = 0, n;
    ecm_row_t    rows[7] = '{
        '{OFS_TX,   1'b0, 32'h0,    32'h0,    1'b0},
        '{OFS_RX,   1'b0, 32'h0,    32'h2000, 1'b0},
        '{OFS_CTRL, 1'b0, 32'h0,    32'h0,    1'b0},
        '{OFS_STAT, 1'b0, 32'h0,    32'h0,    1'b0},
        '{OFS_NP0,  1'b1, 32'h1234, 32'h0,    1'b0},
        '{8'h2c,    1'b1, 32'h5,    32'h0,    1'b1},
        '{OFS_TX,   1'b1, 32'h8011, 32'h0,    1'b0}};

    ecm_mailbox #(.LOCK_CYC_P(LK), .TMO_CYC_P(64)) uut (
        .clock_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .main_init_done_in, .module_init_done_in,
        .trip_valid_in, .trip_code_in, .trip_reinit_in, .trip_reset_in, .reinit_req_out,
        .feedback_initialised_flag_out, .power_en_req_in, .power_stage_en_out,
        .full_nameplate_transfer_en_in, .motor_object_valid_in, .motor_object_in, .pos_in,
        .pos_out, .link_tx_out, .link_tx_valid_out, .link_tx_ready_in, .link_rx_in,
        .link_rx_valid_in, .link_rx_err_in);
    ecm_enc_model enc (.clock_in, .srst_in, .link_tx_in(link_tx_out),
        .link_tx_valid_in(link_tx_valid_out), .link_tx_ready_out(link_tx_ready_in),
        .link_rx_out(link_rx_in), .link_rx_valid_out(link_rx_valid_in),
        .link_rx_err_out(link_rx_err_in), .slow_in(slow), .mute_in(mute),
        .bad_sum_in(bad), .enc_err_in(enc_err));

    always #4 clock_in = ~clock_in;
    always @(posedge clock_in) if (link_tx_valid_out === 1'b1 && link_tx_ready_in === 1'b1)
        seen.push_back(link_tx_out);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k = 0;
        @(posedge clock_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clock_in);
            k++;
        end while (pready_out !== 1'b1 && k < 20);
        if (pready_out !== 1'b1) begin
            fails++;
            wrap_up();
        end
        rd = prdata_out;
        err_seen = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int k = 0;
        do begin
            apb(a, 1'b0, 32'h0);
            k++;
        end while ((rd & m) !== v && k < 400);
        if ((rd & m) !== v) begin
            fails++;
            wrap_up();
        end
    endtask
    task automatic tx_word(input logic [31:0] w);
        apb(OFS_TX, 1'b1, w);
        poll(OFS_TX, 32'hffff_ffff, 32'h0);
    endtask
    task automatic wait_flag(input logic v);
        int k = 0;
        while (feedback_initialised_flag_out !== v && k < 200) begin
            @(posedge clock_in);
            k++;
        end
        if (feedback_initialised_flag_out !== v) begin
            fails++;
            wrap_up();
        end
    endtask
    // Message is address, command, then k filler bytes; the last word carries bit 14
    task automatic err_case(input logic [3:0] m, input logic [7:0] c, input int k,
                            input logic [31:0] e);
        {slow, mute, bad, enc_err} <= m;
        tx_word(32'ha0ff);
        tx_word({16'h0, k == 0 ? 8'hc0 : 8'h80, c});
        for (int i = 1; i <= k; i++) tx_word({16'h0, i == k ? 8'hc0 : 8'h80, 8'h00});
        poll(OFS_RX, 32'hffff_ffff, e);
        check(rd, e);
    endtask

    initial begin
        repeat (100000) @(posedge clock_in);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        check(32'(feedback_initialised_flag_out), 32'h0);
        check(32'(power_stage_en_out), 32'h0);
        foreach (rows[i]) begin
            if (rows[i].w) apb(rows[i].a, 1'b1, rows[i].wd);
            apb(rows[i].a, 1'b0, 32'h0);
            check(rd, rows[i].d);
            check(32'(err_seen), 32'(rows[i].e));
        end
        main_init_done_in <= 1'b1;
        repeat (20) @(posedge clock_in);
        check(32'(feedback_initialised_flag_out), 32'h0);
        module_init_done_in <= 1'b1;
        wait_flag(1'b1);
        repeat (2) @(posedge clock_in);
        check(32'(power_stage_en_out), 32'h1);
        trip_code_in   <= TRIP_LAST;
        trip_valid_in  <= 1'b1;
        trip_reinit_in <= 1'b1;
        @(posedge clock_in);
        trip_valid_in  <= 1'b0;
        wait_flag(1'b0);
        repeat (2) @(posedge clock_in);
        check(32'(feedback_initialised_flag_out), 32'h0);
        check(32'(power_stage_en_out), 32'h0);
        trip_reset_in <= 1'b1;
        @(posedge clock_in);
        trip_reset_in <= 1'b0;
        n = 0;
        repeat (8) begin
            @(posedge clock_in);
            n += int'(reinit_req_out === 1'b1);
        end
        check(32'(n), 32'h1);
        {main_init_done_in, module_init_done_in} <= 2'b00;
        repeat (3) @(posedge clock_in);
        {main_init_done_in, module_init_done_in} <= 2'b11;
        wait_flag(1'b1);
        check(32'(feedback_initialised_flag_out), 32'h1);
        apb(OFS_CTRL, 1'b1, 32'h1);
        apb(OFS_TX, 1'b1, 32'h1f11);
        apb(OFS_TX, 1'b0, 32'h0);
        check(rd, 32'h0011);
        seen.delete();
        tx_word(32'ha0ff);
        tx_word(32'h8077);
        tx_word(32'ha0ff);
        tx_word(32'hc042);
        for (int i = 0; i < 7; i++) begin
            ex = {16'h0, i == 6 ? 8'hc0 : 8'h80, rsp[i]};
            poll(OFS_RX, 32'h8000, 32'h8000);
            check(rd, ex);
            repeat (4) @(posedge clock_in);
            apb(OFS_RX, 1'b0, 32'h0);
            check(rd, ex);
            apb(OFS_RX, 1'b1, 32'h0);
        end
        check(32'(seen.size()), 32'h3);
        check(32'(seen[0]), {23'h0, 8'hff, 1'b0});
        check(32'(seen[1]), {23'h0, 8'h42, 1'b0});
        check(32'(seen[2]), {23'h0, 8'hbd, 1'b1});
        poll(OFS_RX, 32'hffff_ffff, 32'h2000);
        check(rd, 32'h2000);
        err_case(4'h0, 8'h99, 0, 32'h2004);
        err_case(4'h0, 8'h42, 1, 32'h2001);
        err_case(4'h0, 8'h43, 14, 32'h2002);
        err_case(4'h4, 8'h42, 0, 32'h2020);
        err_case(4'ha, 8'h42, 0, 32'h2010);
        err_case(4'h1, 8'h42, 0, 32'h2008);
        // Sync protocol: command byte first, no checksum appended
        {slow, mute, bad, enc_err} <= 4'h0;
        apb(OFS_CTRL, 1'b1, 32'h5);
        seen.delete();
        tx_word(32'ha003);
        tx_word(32'h8001);
        tx_word(32'hc002);
        poll(OFS_RX, 32'h8000, 32'h8000);
        check(rd, 32'h8040);
        check(32'(seen.size()), 32'h3);
        check(32'(seen[2]), {23'h0, 8'h02, 1'b1});
        pos_in <= '{16'h1, 16'h2, 16'h3};
        repeat (2 * LK + 4) @(posedge clock_in);
        check(32'(pos_out !== 48'h0001_0002_0003), 32'h0);
        apb(OFS_CTRL, 1'b1, 32'h3);
        repeat (2 * LK + 4) @(posedge clock_in);
        apb(OFS_STAT, 1'b0, 32'h0);
        check(rd, 32'h3);
        pos_in <= '{16'h4, 16'h5, 16'h6};
        repeat (2 * LK + 4) @(posedge clock_in);
        check(32'(pos_out !== 48'h0001_0002_0003), 32'h0);
        apb(OFS_CTRL, 1'b1, 32'h1);
        repeat (2 * LK + 4) @(posedge clock_in);
        check(32'(pos_out !== 48'h0004_0005_0006), 32'h0);
        motor_object_in <= {16'h7777, 16'h6666, 16'h5555, 16'h4444, 16'h3333, 16'h2222,
                            16'h1111};
        motor_object_valid_in <= 1'b1;
        @(posedge clock_in);
        motor_object_valid_in <= 1'b0;
        apb(OFS_NP0, 1'b0, 32'h0);
        check(rd, 32'h1111);
        apb(8'h28, 1'b0, 32'h0);
        check(rd, 32'h7777);
        // Strap low at a second reset: later object data must not be copied
        {full_nameplate_transfer_en_in, motor_object_valid_in, srst_in} <= 3'b011;
        repeat (10) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        apb(OFS_NP0, 1'b0, 32'h0);
        check(rd, 32'h0);
        wrap_up();
    end
endmodule
